// file: pmsa_pkg.sv
/*
  shared constants and types of the monitor's serial slave and alert logic.
  assumes nothing beyond a systemverilog compiler.
*/
package pmsa_pkg;
  // register pointer values
  localparam logic [7:0] REG_SETUP = 8'h00;
  localparam logic [7:0] REG_SHUNT = 8'h01;
  localparam logic [7:0] REG_RAIL = 8'h02;
  localparam logic [7:0] REG_POWER = 8'h03;
  localparam logic [7:0] REG_CURRENT = 8'h04;
  localparam logic [7:0] REG_SCALE = 8'h05;
  localparam logic [7:0] REG_ALERT = 8'h06;
  localparam logic [7:0] REG_LIMIT = 8'h07;
  // reset values
  localparam logic [15:0] SETUP_RST = 16'h4127;
  localparam logic [15:0] SCALE_RST = 16'h0000;
  localparam logic [15:0] ALERT_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // field positions
  localparam int SETUP_SOFT_RST = 15;
  localparam int MODE_MSB = 2;
  localparam int MSK_SOL = 15;
  localparam int MSK_POL = 11;
  localparam int MSK_CONVERSION_DONE_ENABLE = 10;
  localparam int MSK_AFF = 4;
  localparam int MSK_CONVERSION_DONE_FLAG = 3;
  localparam int MSK_CFG_MSB = 2;
  // bus addressing
  localparam logic [2:0] ADDR_TOP = 3'b100;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  // serial clock range, in khz, against the sampling clock
  localparam int CLK_KHZ = 20000;
  localparam int FAST_MAX_KHZ = 400;
  localparam int HS_MAX_KHZ = 2940;
  localparam int SCL_OVERSAMPLE = CLK_KHZ / FAST_MAX_KHZ;
  // scaling divisors
  localparam int CUR_DIV = 2048;
  localparam int PWR_DIV = 20000;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [1:0] asel_hi;
    logic [1:0] asel_lo;
  } pmsa_pins_s;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] rail;
  } pmsa_sample_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_TX = 3'b110,
    ST_MACK = 3'b111
  } pmsa_state_e;
endpackage

// file: pmsa_sync.sv
/*
  two flip-flop synchroniser, one per bit.
  assumes inputs idle high and that nothing reads the first stage.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsa_sync #(
  parameter int W = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : gen_bit
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
          meta[g] <= 1'b1;
          o_sync[g] <= 1'b1;
        end else begin
          meta[g] <= i_async[g];
          o_sync[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: pmsa_scale.sv
/*
  current and power scaling of a finished conversion.
  assumes i_go is a one-cycle pulse carrying a new sample.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsa_scale
  import pmsa_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire pmsa_pkg::pmsa_sample_s i_sample,
  input wire logic [15:0] i_scale,
  output logic [15:0] o_current,
  output logic [15:0] o_power,
  output logic o_done
);
  logic pend;
  logic [15:0] rail;
  logic signed [32:0] cur_full;
  logic signed [33:0] pwr_full;

  always_comb begin
    cur_full = ($signed(i_sample.shunt) * $signed({1'b0, i_scale})) / 33'(CUR_DIV);
    pwr_full = ($signed({1'b0, rail}) * $signed(o_current)) / 34'(PWR_DIV);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_current <= RESULT_RST;
      o_power <= RESULT_RST;
      rail <= RESULT_RST;
      pend <= 1'b0;
      o_done <= 1'b0;
    end else begin
      pend <= i_go;
      o_done <= pend;
      if (i_go) begin
        o_current <= cur_full[15:0];
        rail <= i_sample.rail;
      end
      if (pend) begin
        o_power <= pwr_full[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: pmsa_top.sv
/*
  serial bus slave, register file and alert pin of a power monitor.
  assumes the converter delivers samples on i_ref_clk with a one-cycle
  valid, and that an outside pad resolves the open-drain enables.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsa_top
  import pmsa_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [1:0] i_addr_select_low,
  input wire logic [1:0] i_addr_select_high,
  output logic o_alert_o,
  output logic o_alert_oe,
  input wire pmsa_pkg::pmsa_sample_s i_sample,
  input wire logic i_sample_valid,
  output logic o_convert_start,
  output logic [2:0] o_adc_mode
);
  import pmsa_pkg::*;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  pmsa_pins_s pins_raw;
  pmsa_pins_s pins;
  logic scl_p, sda_p, scl_rise, scl_fall, start_c, stop_c;
  pmsa_state_e state;
  logic [7:0] sh, ptr, wmsb, byte_in;
  logic [2:0] cnt;
  logic [1:0] wbyte;
  logic rbyte, got8, go, rw, ara, wr_stb, rd_clr, ara_ok;
  logic [6:0] my_addr;
  logic [15:0] adc_setup, scale_factor, alert_select_flags, alert_threshold;
  logic [15:0] shunt_reading, rail_reading, power_result, current_result;
  logic [15:0] rd_word;
  logic conversion_done_flag, limit_event_flag, trig_pend, acc, done, done_d;
  logic [4:0] evt_sel, evt_hit;
  logic hit;
  logic [7:0] tx_first, tx_next;

  // keep only the highest set enable
  function automatic logic [4:0] top_event(input logic [4:0] en);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      if (en[i] && r == 5'h00) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic is_shutdown(input logic [2:0] m);
    return m[1:0] == 2'h0;
  endfunction

  function automatic logic is_triggered(input logic [2:0] m);
    return !m[2] && !is_shutdown(m);
  endfunction

  // byte placed on the bus for read byte idx
  function automatic logic [7:0] tx_byte(input logic idx, input logic ara_q,
                                         input logic [6:0] own, input logic [15:0] w);
    if (ara_q) begin
      return {own, 1'b0};
    end
    return idx ? w[7:0] : w[15:8];
  endfunction

  assign pins_raw = '{scl: i_scl, sda: i_sda, asel_hi: i_addr_select_high,
                      asel_lo: i_addr_select_low};

  // rates above the HS_MAX_KHZ end of the serial clock range are not resolvable here
  pmsa_sync #(.W($bits(pmsa_pins_s))) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= pins.scl;
      sda_p <= pins.sda;
    end
  end

  always_comb begin
    scl_rise = pins.scl && !scl_p;
    scl_fall = !pins.scl && scl_p;
    start_c = pins.scl && scl_p && sda_p && !pins.sda;
    stop_c = pins.scl && scl_p && !sda_p && pins.sda;
    byte_in = {sh[6:0], pins.sda};
    tx_first = tx_byte(1'b0, ara, my_addr, rd_word);
    tx_next = tx_byte(!rbyte, ara, my_addr, rd_word);
  end

  // bus slave sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      sh <= 8'h00;
      cnt <= 3'h0;
      got8 <= 1'b0;
      go <= 1'b0;
      rw <= 1'b0;
      ara <= 1'b0;
      wbyte <= 2'h0;
      rbyte <= 1'b0;
      ptr <= REG_SETUP;
      wmsb <= 8'h00;
      my_addr <= {ADDR_TOP, 4'h0};
      o_sda_oe <= 1'b0;
      o_sda_o <= 1'b0;
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      ara_ok <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      ara_ok <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        cnt <= 3'h0;
        got8 <= 1'b0;
        wbyte <= 2'h0;
        rbyte <= 1'b0;
        o_sda_oe <= 1'b0;
        my_addr <= {ADDR_TOP, pins.asel_hi, pins.asel_lo};
      end else if (stop_c) begin
        state <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh <= byte_in;
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                got8 <= 1'b1;
                if (state == ST_ADDR) begin
                  rw <= byte_in[0];
                  ara <= byte_in[7:1] == ARA_ADDR;
                  go <= byte_in[7:1] == my_addr ||
                        (byte_in[7:1] == ARA_ADDR && byte_in[0] && o_alert_oe);
                end else begin
                  go <= 1'b1;
                  if (wbyte == 2'h0) begin
                    ptr <= byte_in;
                  end else if (wbyte == 2'h1) begin
                    wmsb <= byte_in;
                  end else if (wbyte == 2'h2) begin
                    wr_stb <= 1'b1;
                  end
                  if (wbyte != 2'h3) begin
                    wbyte <= wbyte + 2'h1;
                  end
                end
              end
            end else if (scl_fall && got8) begin
              got8 <= 1'b0;
              state <= go ? ST_ACK : ST_IDLE;
              o_sda_oe <= go;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt <= 3'h0;
              if (rw) begin
                state <= ST_TX;
                sh <= tx_first;
                o_sda_oe <= !tx_first[7];
              end else begin
                state <= ST_RX;
                o_sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise && !o_sda_oe && !pins.sda) begin
              state <= ST_IDLE;
            end else if (scl_fall) begin
              cnt <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                state <= ST_MACK;
                o_sda_oe <= 1'b0;
                ara_ok <= ara;
              end else begin
                sh <= {sh[6:0], 1'b0};
                o_sda_oe <= !sh[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (pins.sda) begin
                state <= ST_IDLE;
              end else begin
                got8 <= 1'b1;
              end
            end else if (scl_fall && got8) begin
              got8 <= 1'b0;
              cnt <= 3'h0;
              rbyte <= !rbyte;
              state <= ST_TX;
              sh <= tx_next;
              o_sda_oe <= !tx_next[7];
              // flags sit in the low byte: clear them only once it is loaded
              rd_clr <= !rbyte && !ara && ptr == REG_ALERT;
            end
          end
          default: begin
            state <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // writable registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      adc_setup <= SETUP_RST;
      scale_factor <= SCALE_RST;
      alert_select_flags <= ALERT_RST;
      alert_threshold <= LIMIT_RST;
    end else if (wr_stb) begin
      case (ptr)
        REG_SETUP: begin
          if (wmsb[SETUP_SOFT_RST - 8]) begin
            adc_setup <= SETUP_RST;
            scale_factor <= SCALE_RST;
            alert_select_flags <= ALERT_RST;
            alert_threshold <= LIMIT_RST;
          end else begin
            adc_setup <= {wmsb, sh};
          end
        end
        REG_SCALE: scale_factor <= {wmsb, sh};
        REG_ALERT: alert_select_flags <= {wmsb, sh};
        REG_LIMIT: alert_threshold <= {wmsb, sh};
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ptr)
      REG_SETUP: rd_word = adc_setup;
      REG_SHUNT: rd_word = shunt_reading;
      REG_RAIL: rd_word = rail_reading;
      REG_POWER: rd_word = power_result;
      REG_CURRENT: rd_word = current_result;
      REG_SCALE: rd_word = scale_factor;
      REG_ALERT: begin
        rd_word = 16'h0000;
        rd_word[MSK_SOL:MSK_CONVERSION_DONE_ENABLE] = alert_select_flags[MSK_SOL:MSK_CONVERSION_DONE_ENABLE];
        rd_word[MSK_AFF] = limit_event_flag;
        rd_word[MSK_CONVERSION_DONE_FLAG] = conversion_done_flag;
        rd_word[MSK_CFG_MSB:0] = alert_select_flags[MSK_CFG_MSB:0];
      end
      REG_LIMIT: rd_word = alert_threshold;
      default: rd_word = 16'h0000;
    endcase
  end

  // conversion control
  always_comb begin
    acc = i_sample_valid && !is_shutdown(adc_setup[MODE_MSB:0]) &&
          (!is_triggered(adc_setup[MODE_MSB:0]) || trig_pend);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      trig_pend <= 1'b0;
      o_convert_start <= 1'b0;
      o_adc_mode <= SETUP_RST[MODE_MSB:0];
      shunt_reading <= RESULT_RST;
      rail_reading <= RESULT_RST;
    end else begin
      o_convert_start <= wr_stb && ptr == REG_SETUP;
      o_adc_mode <= adc_setup[MODE_MSB:0];
      if (wr_stb && ptr == REG_SETUP) begin
        trig_pend <= 1'b1;
      end else if (acc) begin
        trig_pend <= 1'b0;
      end
      if (acc) begin
        shunt_reading <= i_sample.shunt;
        rail_reading <= i_sample.rail;
      end
    end
  end

  pmsa_scale u_scale (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_go(acc),
    .i_sample(i_sample),
    .i_scale(scale_factor),
    .o_current(current_result),
    .o_power(power_result),
    .o_done(done)
  );

  // limit compare on the results of a finished conversion
  always_comb begin
    evt_sel = top_event(alert_select_flags[MSK_SOL:MSK_POL]);
    evt_hit = {$signed(shunt_reading) > $signed(alert_threshold),
               $signed(shunt_reading) < $signed(alert_threshold),
               $signed(rail_reading) > $signed(alert_threshold),
               $signed(rail_reading) < $signed(alert_threshold),
               $signed(power_result) > $signed(alert_threshold)};
    hit = |(evt_sel & evt_hit);
  end

  // flags: a new event wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      done_d <= 1'b0;
      limit_event_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      o_alert_oe <= 1'b0;
      o_alert_o <= 1'b0;
    end else begin
      done_d <= done;
      if (done_d && hit) begin
        limit_event_flag <= 1'b1;
      end else if (rd_clr || ara_ok) begin
        limit_event_flag <= 1'b0;
      end
      if (done_d) begin
        conversion_done_flag <= 1'b1;
      end else if (rd_clr || ara_ok) begin
        conversion_done_flag <= 1'b0;
      end
      o_alert_oe <= limit_event_flag ||
                    (alert_select_flags[MSK_CONVERSION_DONE_ENABLE] && conversion_done_flag);
    end
  end

  a_alert_set: assert property ((done_d && hit) |-> ##2 o_alert_oe)
    else $error("alert not asserted after limit event");
  a_prio_pick: assert property (alert_select_flags[MSK_SOL] |-> evt_sel == 5'h10)
    else $error("top enabled event not selected");
  a_flag_src: assert property (done_d |=> conversion_done_flag)
    else $error("done flag not set after conversion");
  a_conversion_done_enable_off: assert property ((!alert_select_flags[MSK_CONVERSION_DONE_ENABLE] && !limit_event_flag)
                               |=> !o_alert_oe)
    else $error("alert driven without enabled source");
  a_ptr_load: assert property ((state == ST_RX && scl_rise && cnt == 3'h7 && wbyte == 2'h0
                                && !start_c && !stop_c) |=> ptr == $past(byte_in))
    else $error("command byte not loaded into pointer");
  a_ptr_hold: assert property ((state == ST_TX || state == ST_MACK) |=> $stable(ptr))
    else $error("pointer changed during read");
  a_ack_drive: assert property (state == ST_ACK |-> o_sda_oe)
    else $error("acknowledge not driven");
  a_arb_lost: assert property ((state == ST_TX && scl_rise && !o_sda_oe && !pins.sda)
                               |=> state == ST_IDLE)
    else $error("lost arbitration not abandoned");
  a_ara_release: assert property ((ara_ok && !done_d) |=> !limit_event_flag
                                  && !conversion_done_flag ##1 !o_alert_oe)
    else $error("alert not released after response");
  a_trig_hold: assert property ((is_triggered(adc_setup[MODE_MSB:0]) && !trig_pend)
                                |=> $stable(shunt_reading))
    else $error("triggered mode updated without setup write");
  a_alert_idle: assert property (!(limit_event_flag || (alert_select_flags[MSK_CONVERSION_DONE_ENABLE]
                                 && conversion_done_flag)) |=> !o_alert_oe)
    else $error("alert held with nothing pending");

  c_reg_write: cover property (wr_stb);
  c_read_msb: cover property (state == ST_MACK ##[1:300] state == ST_TX);
  c_ara_done: cover property (ara_ok);
  c_alert_on: cover property ($rose(o_alert_oe));
endmodule
`default_nettype wire

// file: pmsa_master.sv
/*
  bus master model for the monitor's two-wire slave: start, stop and byte tasks.
  assumes a pull-up on the data line, resolved by the bench, and i_ref_clk at 20 mhz.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsa_master (
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // clock stands high outside frames, data high means released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // also serves as repeated start; waits out the slave's ack release
  task automatic start();
    o_sda = 1'b1;
    tick(8);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b0;
    tick(8);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    tick(6);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b1;
    tick(8);
  endtask

  // data moves mid low phase, sampled mid high phase, 4 clocks each phase
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // master acks each byte it wants followed by another, nacks the last
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

// file: pmsa_top_test.sv
/*
  self-checking bench of the monitor's serial slave, registers and alert pin.
  assumes pmsa_master drives the bus and the data line has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module pmsa_top_test;
  import pmsa_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [1:0] sel_lo = 2'b00;
  logic [1:0] sel_hi = 2'b00;
  pmsa_pkg::pmsa_sample_s smp = '0;
  logic smp_valid = 1'b0;
  wire mst_scl;
  wire mst_sda;
  wire sda_line;
  logic sda_o;
  logic sda_oe;
  logic alert_o;
  logic alert_oe;
  logic conv_start;
  logic [2:0] adc_mode;
  logic [6:0] own = 7'h40;
  int failures = 0;
  int checked = 0;
  int starts = 0;

  always #25 i_ref_clk = ~i_ref_clk;
  assign sda_line = mst_sda & ~(sda_oe & ~sda_o);

  pmsa_master u_mst (.i_ref_clk(i_ref_clk), .i_sda(sda_line), .o_scl(mst_scl),
    .o_sda(mst_sda));
  pmsa_top u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(mst_scl),
    .i_sda(sda_line), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_select_low(sel_lo),
    .i_addr_select_high(sel_hi), .o_alert_o(alert_o), .o_alert_oe(alert_oe),
    .i_sample(smp), .i_sample_valid(smp_valid), .o_convert_start(conv_start),
    .o_adc_mode(adc_mode));

  always @(posedge i_ref_clk) begin
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] d);
    logic a;
    u_mst.start();
    u_mst.put_byte({own, 1'b0}, a);
    check("addr ack", 16'h1, {15'h0, a});
    u_mst.put_byte(ptr, a);
    check("cmd ack", 16'h1, {15'h0, a});
    u_mst.put_byte(d[15:8], a);
    check("msb ack", 16'h1, {15'h0, a});
    u_mst.put_byte(d[7:0], a);
    check("lsb ack", 16'h1, {15'h0, a});
    u_mst.stop();
  endtask

  task automatic rd_check(input string what, input logic [7:0] ptr, input logic setp,
    input logic [15:0] exp);
    logic a;
    logic [15:0] d;
    if (setp) begin
      u_mst.start();
      u_mst.put_byte({own, 1'b0}, a);
      u_mst.put_byte(ptr, a);
    end
    u_mst.start();
    u_mst.put_byte({own, 1'b1}, a);
    check("read ack", 16'h1, {15'h0, a});
    u_mst.get_byte(1'b1, d[15:8]);
    u_mst.get_byte(1'b0, d[7:0]);
    u_mst.stop();
    check(what, exp, d);
  endtask

  task automatic sample(input logic [15:0] sh, input logic [15:0] rl);
    @(posedge i_ref_clk);
    #1;
    smp.shunt = sh;
    smp.rail = rl;
    smp_valid = 1'b1;
    u_mst.tick(1);
    smp_valid = 1'b0;
    u_mst.tick(8);
  endtask

  // event bit and limit for each event; every event trips
  logic [15:0] ev_bit [5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
  logic [15:0] ev_lim [5] = '{16'h1000, 16'h2000, 16'h2000, 16'h3000, 16'h1000};

  initial begin
    logic a;
    logic [7:0] b;
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    u_mst.tick(4);
    check("mode after reset", 16'h7, {13'h0, adc_mode});
    check("alert after reset", 16'h0, {15'h0, alert_oe});
    check("data drive value", 16'h0, {15'h0, sda_o});
    rd_check("setup reset", REG_SETUP, 1'b1, 16'h4127);
    $display("test reset done");

    for (int k = 0; k < 16; k++) begin
      sel_hi = k[3:2];
      sel_lo = k[1:0];
      own = {3'b100, k[3:0]};
      u_mst.tick(4);
      u_mst.start();
      u_mst.put_byte({own, 1'b0}, a);
      u_mst.stop();
      check("own address ack", 16'h1, {15'h0, a});
      u_mst.start();
      u_mst.put_byte({own ^ 7'h01, 1'b0}, a);
      u_mst.stop();
      check("other address ack", 16'h0, {15'h0, a});
    end
    sel_hi = 2'b10;
    sel_lo = 2'b01;
    own = 7'h49;
    u_mst.tick(4);
    $display("test address done");

    wr_reg(REG_SCALE, 16'h0a00);
    rd_check("scale", REG_SCALE, 1'b1, 16'h0a00);
    rd_check("scale again", REG_SCALE, 1'b0, 16'h0a00);
    rd_check("unmapped", 8'h08, 1'b1, 16'h0000);
    sample(16'h1f40, 16'h2580);
    check("alert without enable", 16'h0, {15'h0, alert_oe});
    rd_check("current", REG_CURRENT, 1'b1, 16'h2710);
    rd_check("power", REG_POWER, 1'b1, 16'h12c0);
    wr_reg(REG_SHUNT, 16'h1234);
    rd_check("shunt read only", REG_SHUNT, 1'b1, 16'h1f40);
    $display("test scaling done");

    for (int i = 0; i < 5; i++) begin
      wr_reg(REG_LIMIT, ev_lim[i]);
      wr_reg(REG_ALERT, ev_bit[i]);
      sample(16'h1f40, 16'h2580);
      check("alert on event", 16'h1, {15'h0, alert_oe});
      check("alert drive value", 16'h0, {15'h0, alert_o});
      rd_check("event flag", REG_ALERT, 1'b1, ev_bit[i] | 16'h0018);
      check("alert after flag read", 16'h0, {15'h0, alert_oe});
    end
    wr_reg(REG_LIMIT, 16'h0001);
    wr_reg(REG_ALERT, 16'hc000);
    sample(16'hffff, 16'h2580);
    check("top event wins signed", 16'h0, {15'h0, alert_oe});
    wr_reg(REG_LIMIT, 16'h7fff);
    wr_reg(REG_ALERT, 16'h8400);
    sample(16'h1f40, 16'h2580);
    check("alert on done", 16'h1, {15'h0, alert_oe});
    rd_check("done flag", REG_ALERT, 1'b1, 16'h8408);
    $display("test alert done");

    u_mst.start();
    u_mst.put_byte({ARA_ADDR, 1'b1}, a);
    u_mst.stop();
    check("response idle ack", 16'h0, {15'h0, a});
    wr_reg(REG_LIMIT, 16'h1000);
    wr_reg(REG_ALERT, 16'h8000);
    sample(16'h1f40, 16'h2580);
    u_mst.start();
    u_mst.put_byte({ARA_ADDR, 1'b1}, a);
    u_mst.put_byte(8'h80, a);
    u_mst.stop();
    check("alert kept on loss", 16'h1, {15'h0, alert_oe});
    u_mst.start();
    u_mst.put_byte({ARA_ADDR, 1'b1}, a);
    check("response ack", 16'h1, {15'h0, a});
    u_mst.get_byte(1'b0, b);
    u_mst.stop();
    check("response address", {8'h0, own, 1'b0}, {8'h0, b});
    check("alert released", 16'h0, {15'h0, alert_oe});
    $display("test response done");

    wr_reg(REG_ALERT, 16'h0000);
    wr_reg(REG_SETUP, 16'h4121);
    check("convert start", 16'h1, starts[15:0]);
    check("mode triggered", 16'h1, {13'h0, adc_mode});
    sample(16'h0100, 16'h2580);
    sample(16'h0200, 16'h2580);
    rd_check("held result", REG_SHUNT, 1'b1, 16'h0100);
    wr_reg(REG_SETUP, 16'h4120);
    sample(16'h0300, 16'h2580);
    rd_check("shutdown held", REG_SHUNT, 1'b1, 16'h0100);
    wr_reg(REG_SETUP, 16'hc127);
    rd_check("soft reset setup", REG_SETUP, 1'b1, 16'h4127);
    rd_check("soft reset scale", REG_SCALE, 1'b1, 16'h0000);
    check("convert start count", 16'h3, starts[15:0]);
    $display("test triggered done");
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge i_ref_clk);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
